// *** verilog/sli_consts.vh ***
/*
 Constants of the safety lock status indicator: clock rate, times,
 derived cycle counts, register offsets, field positions, reset values.
 Assumes a 250 MHz system clock and a 40-bit wide long timer.
*/
// Operation
// - Valid actuator: green steady if outputs high
// - No valid actuator: outputs low, red
// - Lock lamp dark without lock request
// - Lock request: green flash, steady once engaged
// - Lock engage or release error: yellow
// - Invalid enable inputs: diagnostic lamp yellow
// - Self-test: all lamps alternate 2 Hz
// - Delivery state: red, dark, alternating 4 Hz
// - Teaching: green 4 Hz, diagnostic alternating 4 Hz
// - Teach success: green, yellow 4 Hz, outputs off
// - Enables invalid: green 1 Hz, yellow, off
// - All valid: outputs on, green steady
// - Supply out of range: diagnostic red 1 Hz
// - No restart in five minutes: teach failed
// - Retry locking, ten minutes then safe
`ifndef SLI_CONSTS_VH
`define SLI_CONSTS_VH

// ****************************************
// Timing
// ****************************************
`define SLI_CLK_HZ 250000000
`define SLI_FAST_HZ 4
`define SLI_HALF_CYC (`SLI_CLK_HZ / (2 * `SLI_FAST_HZ))
`define SLI_POST_MS 1000
`define SLI_POST_CYC (40'd`SLI_POST_MS * (40'd`SLI_CLK_HZ / 40'd1000))
`define SLI_TEACH_S 300
`define SLI_TEACH_CYC (40'd`SLI_TEACH_S * 40'd`SLI_CLK_HZ)
`define SLI_LOCK_S 600
`define SLI_LOCK_CYC (40'd`SLI_LOCK_S * 40'd`SLI_CLK_HZ)

// ****************************************
// Registers
// ****************************************
`define SLI_ADDR_CTRL 8'h00
`define SLI_ADDR_STATE 8'h04
`define SLI_ADDR_INPUTS 8'h08
`define SLI_CTRL_PERMIT 0
`define SLI_CTRL_RETRY 1
`define SLI_CTRL_RST 2'h3
`define SLI_STATE_FSM_LSB 0
`define SLI_STATE_LAMP_LSB 8
`define SLI_STATE_OUT_LSB 16
`define SLI_STATE_CMD 18
`define SLI_STATE_MISS 19

`endif

// *** verilog/sli_blink.v ***
/*
 Flash phase generator: a prescaler of one half period of the fastest
 rate and a three-bit phase counter whose bits are the fastest and the slower rates.
 Assumes a synchronous active-high reset and a clock enable.
*/
`timescale 1ns/1ps

module sli_blink #(
  parameter [31:0] HALF_CYC = 32'd31250000
) (
  // Clock and reset
  input wire clk_sys_i,
  input wire rst_i,
  input wire ce_i,
  // Phases: bit0 fastest, each next bit half the rate
  output reg [2:0] phase_o
);

  // Prescaler of one half period
  reg [31:0] pre;

  // ****************************************
  // Prescaler and phase counter
  // ****************************************
  // Every bit toggles on a whole count, so duty is exactly half
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      pre <= 32'h0;
      phase_o <= 3'h0;
    end else if (ce_i) begin
      if (pre == HALF_CYC - 32'h1) begin
        pre <= 32'h0;
        phase_o <= phase_o + 3'h1;
      end else begin
        pre <= pre + 32'h1;
      end
    end
  end

endmodule

// *** verilog/sli_indicator.v ***
/*
 Status and indication logic of a safety locking switch: device state
 machine, lamp decoding, safety output pair and the lock retry timer,
 with a small register port for control and status.
 Assumes inputs synchronous to clk_sys_i and a synchronous reset that
 stands for a supply cycle.
*/
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ps
`include "sli_consts.vh"

module sli_indicator #(
  parameter [31:0] P_HALF_CYC = `SLI_HALF_CYC,
  parameter [39:0] P_POST_CYC = `SLI_POST_CYC,
  parameter [39:0] P_TEACH_CYC = `SLI_TEACH_CYC,
  parameter [39:0] P_LOCK_CYC = `SLI_LOCK_CYC
) (
  // Clock, reset, enable
  input wire clk_sys_i,
  input wire rst_i,
  input wire ce_i,
  // Actuator and teach-in status
  input wire act_valid_i,
  input wire act_old_i,
  input wire delivery_i,
  input wire teach_busy_i,
  input wire teach_done_i,
  input wire teach_abort_i,
  // Lock and enable inputs
  input wire lock_req_i,
  input wire lock_engaged_i,
  input wire lock_err_i,
  input wire enable1_i,
  input wire enable2_i,
  // Supply monitor
  input wire supply_bad_i,
  // Register port
  input wire [7:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  // Lamps
  output reg status_red_o,
  output reg status_green_o,
  output reg lock_yellow_o,
  output reg lock_green_o,
  output reg diagnostic_lamp_red_o,
  output reg diagnostic_lamp_yellow_o,
  // Safety outputs and lock actuation
  output reg [1:0] safety_output_pair_o,
  output reg lock_cmd_o
);

  // ****************************************
  // States
  // ****************************************
  localparam [6:0] ST_POST = 7'h01;
  localparam [6:0] ST_DELIV = 7'h02;
  localparam [6:0] ST_TEACH = 7'h04;
  localparam [6:0] ST_TOK = 7'h08;
  localparam [6:0] ST_TFAIL = 7'h10;
  localparam [6:0] ST_RUN = 7'h20;
  localparam [6:0] ST_SAFE = 7'h40;
  // State, timer and control
  reg [6:0] state;
  reg [6:0] next_state;
  reg [39:0] tmr; // Cycles in the current phase
  reg [39:0] next_tmr;
  reg miss; // Teach failed by missed restart
  reg next_miss;
  reg [1:0] ctrl; // Output permit, lock retry enable
  // Flash phases
  wire [2:0] phase;
  wire f4; // 4 Hz square
  wire f2; // 2 Hz square
  wire f1; // 1 Hz square
  // Decoded conditions
  wire en_ok; // Both enable inputs valid
  wire retrying; // Lock attempt under way
  // Next lamp and output values
  reg next_st_r;
  reg next_st_g;
  reg next_lk_y;
  reg next_lk_g;
  reg next_dg_r;
  reg next_dg_y;
  reg next_out;
  reg next_cmd;

  // ****************************************
  // Flash generator
  // ****************************************
  sli_blink #(
    .HALF_CYC(P_HALF_CYC)
  ) u_blink (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .phase_o(phase)
  );

  assign f4 = phase[0];
  assign f2 = phase[1];
  assign f1 = phase[2];
  assign en_ok = enable1_i & enable2_i;
  // Locking is retried while an actuator is there and lock is asked
  assign retrying = (state == ST_RUN) & act_valid_i & lock_req_i &
                    ~lock_engaged_i & ctrl[`SLI_CTRL_RETRY];

  // ****************************************
  // State machine, next state
  // ****************************************
  always @* begin
    next_state = state;
    next_tmr = tmr + 40'h1;
    next_miss = miss;
    case (state)
      ST_POST: begin
        // Self-test for a fixed time, then pick the mode
        if (tmr >= P_POST_CYC - 40'h1) begin
          next_state = delivery_i ? ST_DELIV : ST_RUN;
        end
      end
      ST_DELIV: begin
        // Wait for an actuator to teach
        if (teach_busy_i) begin
          next_state = ST_TEACH;
        end else if (~delivery_i) begin
          next_state = ST_RUN;
        end
      end
      ST_TEACH: begin
        // Teach in progress
        if (teach_abort_i) begin
          next_state = ST_TFAIL;
          next_miss = 1'b0;
        end else if (teach_done_i) begin
          next_state = ST_TOK;
        end
      end
      ST_TOK: begin
        // Only a supply cycle (reset) leaves this state in time
        if (tmr >= P_TEACH_CYC - 40'h1) begin
          next_state = ST_TFAIL;
          next_miss = 1'b1;
        end
      end
      ST_RUN: begin
        // Replacement teach or lock timeout
        if (teach_busy_i) begin
          next_state = ST_TEACH;
        end else if (~retrying) begin
          next_tmr = 40'h0;
        end else if (tmr >= P_LOCK_CYC - 40'h1) begin
          next_state = ST_SAFE;
        end
      end
      ST_TFAIL, ST_SAFE: begin
        // Held until the supply is cycled
        next_state = state;
      end
      default: begin
        next_state = ST_SAFE;
      end
    endcase
    // Timer restarts on every change of state
    if (next_state != state) begin
      next_tmr = 40'h0;
    end
  end

  // ****************************************
  // Lamp and output decode
  // ****************************************
  always @* begin
    next_st_r = 1'b0;
    next_st_g = 1'b0;
    next_lk_y = 1'b0;
    next_lk_g = 1'b0;
    next_dg_r = 1'b0;
    next_dg_y = 1'b0;
    next_out = 1'b0;
    next_cmd = 1'b0;
    case (state)
      ST_POST: begin
        // All lamps alternate colours, outputs off
        next_st_r = f2;
        next_st_g = ~f2;
        next_lk_y = f2;
        next_lk_g = ~f2;
        next_dg_r = f2;
        next_dg_y = ~f2;
      end
      ST_DELIV: begin
        // Ready for teach-in, lock lamp dark
        next_st_r = 1'b1;
        next_dg_r = f4;
        next_dg_y = ~f4;
      end
      ST_TEACH: begin
        // Teach in progress
        next_st_g = f4;
        next_dg_r = f4;
        next_dg_y = ~f4;
      end
      ST_TOK: begin
        // Taught, waiting for supply cycle
        next_st_g = f4;
        next_dg_y = f4;
      end
      ST_TFAIL: begin
        // Failed teach, red/green alternating
        next_st_r = f4;
        next_st_g = ~f4;
        next_dg_r = miss ? f4 : 1'b1;
      end
      ST_RUN: begin
        // Outputs need actuator, enables, supply and permit
        next_out = act_valid_i & en_ok & ~supply_bad_i &
                   ctrl[`SLI_CTRL_PERMIT];
        if (~act_valid_i) begin
          next_st_r = 1'b1;
        end else if (next_out) begin
          next_st_g = 1'b1;
        end else begin
          next_st_g = f1;
        end
        // Lock lamp: error first, then request and engagement
        if (lock_err_i) begin
          next_lk_y = 1'b1;
        end else if (~lock_req_i) begin
          next_lk_g = 1'b0;
        end else if (lock_engaged_i) begin
          next_lk_g = 1'b1;
        end else begin
          next_lk_g = f1;
        end
        // Diagnostic lamp: supply, old actuator, enables
        if (supply_bad_i) begin
          next_dg_r = f1;
        end else if (~act_valid_i & act_old_i) begin
          next_dg_y = f1;
        end else if (~en_ok) begin
          next_dg_y = 1'b1;
        end
        next_cmd = retrying;
      end
      ST_SAFE: begin
        // Locking gave up: safe state indication
        next_st_r = f1;
        next_lk_y = 1'b1;
        next_dg_r = f1;
      end
      default: begin
        next_st_r = 1'b1;
      end
    endcase
  end

  // ****************************************
  // State, timer and output registers
  // ****************************************
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      state <= ST_POST;
      tmr <= 40'h0;
      miss <= 1'b0;
      status_red_o <= 1'b0;
      status_green_o <= 1'b0;
      lock_yellow_o <= 1'b0;
      lock_green_o <= 1'b0;
      diagnostic_lamp_red_o <= 1'b0;
      diagnostic_lamp_yellow_o <= 1'b0;
      safety_output_pair_o <= 2'h0;
      lock_cmd_o <= 1'b0;
    end else if (ce_i) begin
      state <= next_state;
      tmr <= next_tmr;
      miss <= next_miss;
      status_red_o <= next_st_r;
      status_green_o <= next_st_g;
      lock_yellow_o <= next_lk_y;
      lock_green_o <= next_lk_g;
      diagnostic_lamp_red_o <= next_dg_r;
      diagnostic_lamp_yellow_o <= next_dg_y;
      // Both channels switch together
      safety_output_pair_o <= {2{next_out}};
      lock_cmd_o <= next_cmd;
    end
  end

  // ****************************************
  // Register port
  // ****************************************
  // Control register write
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      ctrl <= `SLI_CTRL_RST;
    end else if (ce_i && wr_i && addr_i == `SLI_ADDR_CTRL) begin
      ctrl <= wdata_i[1:0];
    end
  end

  // Read data stand one cycle after the strobe, zero otherwise
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      rdata_o <= 32'h0;
    end else if (ce_i) begin
      rdata_o <= 32'h0;
      if (rd_i) begin
        case (addr_i)
          `SLI_ADDR_CTRL: begin
            rdata_o <= {30'h0, ctrl};
          end
          `SLI_ADDR_STATE: begin
            rdata_o[`SLI_STATE_FSM_LSB +: 7] <= state;
            rdata_o[`SLI_STATE_LAMP_LSB +: 6] <= {
              diagnostic_lamp_yellow_o, diagnostic_lamp_red_o,
              lock_yellow_o, lock_green_o,
              status_red_o, status_green_o};
            rdata_o[`SLI_STATE_OUT_LSB +: 2] <= safety_output_pair_o;
            rdata_o[`SLI_STATE_CMD] <= lock_cmd_o;
            rdata_o[`SLI_STATE_MISS] <= miss;
          end
          `SLI_ADDR_INPUTS: begin
            rdata_o <= {20'h0, supply_bad_i, enable2_i, enable1_i,
                        lock_err_i, lock_engaged_i, lock_req_i,
                        teach_abort_i, teach_done_i, teach_busy_i,
                        delivery_i, act_old_i, act_valid_i};
          end
          default: begin
            rdata_o <= 32'h0; // Unmapped reads zero
          end
        endcase
      end
    end
  end

endmodule

// *** verif/sli_indicator_properties.sv ***
/*
 Checker of lamp, output and register port relations of sli_indicator.
 Assumes it is bound to the indicator and sees only its ports.
*/
`timescale 1ns/1ps
module sli_indicator_properties (
  // Clock, reset, enable
  input wire clk_sys_i,
  input wire rst_i,
  input wire ce_i,
  // Device inputs
  input wire act_valid_i,
  input wire teach_busy_i,
  input wire lock_req_i,
  input wire lock_err_i,
  input wire enable1_i,
  input wire enable2_i,
  input wire supply_bad_i,
  // Register port
  input wire [7:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [31:0] rdata_o,
  // Lamps and outputs
  input wire status_red_o,
  input wire status_green_o,
  input wire lock_yellow_o,
  input wire lock_green_o,
  input wire diagnostic_lamp_red_o,
  input wire diagnostic_lamp_yellow_o,
  input wire [1:0] safety_output_pair_o,
  input wire lock_cmd_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // Control write one cycle back, whose permit change is still on its way
  reg wr_d = 1'b0;
  always @(posedge clk_sys_i) wr_d <= wr_i;
  // Outputs on, so the device runs; no teach start, control write or lock retry
  wire quiet = ce_i && safety_output_pair_o == 2'b11 && !teach_busy_i && !wr_i && !wr_d && !lock_cmd_o;
  property p_pair; safety_output_pair_o[0] == safety_output_pair_o[1]; endproperty
  a_pair: assert property (p_pair) else $error("output pair bits differ");
  property p_no_act; ce_i && !act_valid_i |=> safety_output_pair_o == 2'b00; endproperty
  a_no_act: assert property (p_no_act) else $error("outputs on without actuator");
  property p_dark; quiet && !lock_req_i && !lock_err_i |=> !lock_green_o && !lock_yellow_o; endproperty
  a_dark: assert property (p_dark) else $error("lock lamp lit without request");
  property p_ok;
    quiet && act_valid_i && enable1_i && enable2_i && !supply_bad_i |=> safety_output_pair_o == 2'b11
      && status_green_o && !status_red_o;
  endproperty
  a_ok: assert property (p_ok) else $error("outputs or green missing");
  property p_en_bad;
    quiet && act_valid_i && !(enable1_i && enable2_i) && !supply_bad_i |=> safety_output_pair_o == 2'b00
      && diagnostic_lamp_yellow_o && !diagnostic_lamp_red_o;
  endproperty
  a_en_bad: assert property (p_en_bad) else $error("enable fault not shown");
  property p_supply; quiet && supply_bad_i |=> safety_output_pair_o == 2'b00 && !diagnostic_lamp_yellow_o;
  endproperty
  a_supply: assert property (p_supply) else $error("supply fault not shown");
  property p_st_excl; !(status_red_o && status_green_o); endproperty
  a_st_excl: assert property (p_st_excl) else $error("status lamp two colours");
  property p_lk_excl; !(lock_yellow_o && lock_green_o); endproperty
  a_lk_excl: assert property (p_lk_excl) else $error("lock lamp two colours");
  property p_post; $fell(rst_i) |-> (safety_output_pair_o == 2'b00) [*8]; endproperty
  a_post: assert property (p_post) else $error("outputs on during self-test");
  property p_rd_idle; ce_i && !rd_i |=> rdata_o == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_ctrl;
    ce_i && wr_i && addr_i == 8'h00 ##1 !wr_i ##1 ce_i && rd_i && addr_i == 8'h00
      |=> rdata_o[1:0] == $past(wdata_i[1:0], 3);
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control readback wrong");
  c_locked: cover property (safety_output_pair_o == 2'b11 && lock_green_o);
  c_safe: cover property (lock_yellow_o && diagnostic_lamp_red_o);
  c_read: cover property (rd_i ##1 rdata_o != 32'h0);
endmodule

bind sli_indicator sli_indicator_properties sli_indicator_properties_i (.clk_sys_i(clk_sys_i),
  .rst_i(rst_i), .ce_i(ce_i), .act_valid_i(act_valid_i), .teach_busy_i(teach_busy_i),
  .lock_req_i(lock_req_i), .lock_err_i(lock_err_i), .enable1_i(enable1_i), .enable2_i(enable2_i),
  .supply_bad_i(supply_bad_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .status_red_o(status_red_o), .status_green_o(status_green_o),
  .lock_yellow_o(lock_yellow_o), .lock_green_o(lock_green_o), .diagnostic_lamp_red_o(diagnostic_lamp_red_o),
  .diagnostic_lamp_yellow_o(diagnostic_lamp_yellow_o), .safety_output_pair_o(safety_output_pair_o),
  .lock_cmd_o(lock_cmd_o));

// *** verif/sli_ctrl_model.sv ***
/*
 Machine safety controller and lock bolt model.
 Assumes the bench steers it by levels changed after clk_sys_i edges.
*/
`timescale 1ns/1ps
module sli_ctrl_model (
  // Clock and reset
  input wire clk_sys_i,
  input wire rst_i,
  // Bench steering
  input wire want_lock_i,
  input wire en_ok_i,
  input wire stuck_i,
  // Towards the indicator
  output wire lock_req_o,
  output wire enable1_o,
  output wire enable2_o,
  output reg lock_engaged_o
);
  reg [2:0] travel; // Bolt travel time
  assign lock_req_o = want_lock_i;
  // Only the second enable drops on a fault
  assign enable1_o = 1'b1;
  assign enable2_o = en_ok_i;
  // Bolt ends four cycles after request, never when blocked
  always @(posedge clk_sys_i) begin
    travel <= (rst_i || !want_lock_i || stuck_i) ? 3'h0 : {travel[1:0], 1'b1};
    lock_engaged_o <= travel[2] && want_lock_i && !stuck_i;
  end
endmodule

// *** verif/sli_indicator_bench.sv ***
/*
 Self-checking bench of sli_indicator with short timing parameters.
 Assumes the checker is bound and the controller model in verif/.
*/
`timescale 1ns/1ps
module sli_indicator_bench;
  reg clk_sys_i = 1'b0;
  reg rst_i = 1'b1;
  reg ce = 1'b1, act = 1'b0, old = 1'b0, dlv = 1'b0, busy = 1'b0, done = 1'b0, abrt = 1'b0;
  reg err = 1'b0, sbad = 1'b0, want = 1'b0, enok = 1'b1, stuck = 1'b0, wr = 1'b0, rd = 1'b0;
  reg [7:0] addr = 8'h00;
  reg [31:0] wdata = 32'h0;
  wire [31:0] rdata;
  wire [5:0] lamp; // Diagnostic_lamp y, diagnostic_lamp r, lock y, lock g, status r, status g
  wire [1:0] pair;
  wire req, en1, en2, eng, lcmd;
  integer miscompares = 0, checks = 0, n;
  always #2 clk_sys_i = ~clk_sys_i;
  sli_indicator #(.P_HALF_CYC(32'd4), .P_POST_CYC(40'd20), .P_TEACH_CYC(40'd200), .P_LOCK_CYC(40'd300))
  sli_indicator_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce), .act_valid_i(act), .act_old_i(old),
    .delivery_i(dlv), .teach_busy_i(busy), .teach_done_i(done), .teach_abort_i(abrt), .lock_req_i(req),
    .lock_engaged_i(eng), .lock_err_i(err), .enable1_i(en1), .enable2_i(en2), .supply_bad_i(sbad),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .status_red_o(lamp[1]),
    .status_green_o(lamp[0]), .lock_yellow_o(lamp[3]), .lock_green_o(lamp[2]),
    .diagnostic_lamp_red_o(lamp[4]), .diagnostic_lamp_yellow_o(lamp[5]), .safety_output_pair_o(pair),
    .lock_cmd_o(lcmd));
  sli_ctrl_model sli_ctrl_model_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .want_lock_i(want),
    .en_ok_i(enok), .stuck_i(stuck), .lock_req_o(req), .enable1_o(en1), .enable2_o(en2),
    .lock_engaged_o(eng));
  task chk(input string nm, input [31:0] e, input [31:0] s);
    checks = checks + 1;
    if (s !== e) begin
      miscompares = miscompares + 1;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask
  task tick(input integer k);
    repeat (k) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask
  task wreg(input [7:0] a, input [31:0] d);
    @(posedge clk_sys_i) {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge clk_sys_i) wr <= 1'b0;
  endtask
  task rreg(input [7:0] a, input [31:0] m, input [31:0] e, input string nm);
    @(posedge clk_sys_i) {addr, rd} <= {a, 1'b1};
    @(posedge clk_sys_i) rd <= 1'b0;
    @(negedge clk_sys_i) chk(nm, e, rdata & m);
  endtask
  // Counts lit cycles of one lamp over a window
  task duty(input integer b, input integer len, input integer e, input string nm);
    n = 0;
    repeat (len) begin
      @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      n = n + lamp[b];
    end
    chk(nm, e, n);
  endtask
  // Supply cycle, optionally in delivery state
  task restart(input d);
    @(posedge clk_sys_i) {rst_i, dlv} <= {1'b1, d};
    repeat (3) @(posedge clk_sys_i);
    rst_i <= 1'b0;
  endtask
  task give_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk_sys_i);
    miscompares = miscompares + 1;
    give_verdict;
  end
  initial begin
    restart(1'b0);
    duty(0, 16, 8, "self-test green");
    tick(6);
    rreg(8'h04, 32'h7F, 32'h20, "state run");
    rreg(8'h00, 32'hFFFFFFFF, 32'h3, "ctrl reset");
    rreg(8'h0C, 32'hFFFFFFFF, 32'h0, "unmapped");
    rreg(8'h08, 32'hFFFFFFFF, 32'h600, "inputs");
    chk("no actuator pair", 0, pair);
    chk("no actuator red", 1, lamp[1]);
    @(posedge clk_sys_i) {act, want} <= 2'b11;
    tick(8);
    chk("run pair", 3, pair);
    duty(2, 32, 32, "lock steady");
    @(posedge clk_sys_i) err <= 1'b1;
    tick(2);
    chk("lock error", 1, lamp[3]);
    @(posedge clk_sys_i) {err, want} <= 2'b00;
    tick(2);
    chk("lock dark", 0, lamp[3:2]);
    chk("run green", 1, lamp[0]);
    @(posedge clk_sys_i) enok <= 1'b0;
    tick(2);
    chk("enable pair", 0, pair);
    chk("enable yellow", 1, lamp[5]);
    duty(0, 32, 16, "green 1hz");
    @(posedge clk_sys_i) enok <= 1'b1;
    @(posedge clk_sys_i) sbad <= 1'b1;
    duty(4, 32, 16, "supply red");
    chk("supply pair", 0, pair);
    @(posedge clk_sys_i) {sbad, act, old} <= 3'b001;
    duty(5, 32, 16, "old yellow");
    @(posedge clk_sys_i) {act, old} <= 2'b10;
    wreg(8'h00, 32'h0);
    tick(2);
    chk("permit off", 0, pair);
    wreg(8'h00, 32'h3);
    rreg(8'h00, 32'hFFFFFFFF, 32'h3, "ctrl");
    @(posedge clk_sys_i) {want, stuck} <= 2'b11;
    tick(2);
    chk("retry", 1, lcmd);
    duty(2, 32, 16, "lock flash");
    tick(300);
    rreg(8'h04, 32'h7F, 32'h40, "state safe");
    chk("safe yellow", 1, lamp[3]);
    @(posedge clk_sys_i) {want, stuck, act} <= 3'b000;
    restart(1'b1);
    tick(25);
    rreg(8'h04, 32'h7F, 32'h02, "state delivery");
    chk("delivery lamps", 2, lamp[3:0]);
    duty(4, 16, 8, "delivery diagnostic_lamp");
    @(posedge clk_sys_i) busy <= 1'b1;
    tick(2);
    rreg(8'h04, 32'h7F, 32'h04, "state teach");
    duty(0, 16, 8, "teach green");
    @(posedge clk_sys_i) {busy, done} <= 2'b01;
    tick(2);
    rreg(8'h04, 32'h7F, 32'h08, "state taught");
    duty(5, 16, 8, "taught yellow");
    chk("taught pair", 0, pair);
    // Clock enable low holds the restart timer for a while
    @(posedge clk_sys_i) {done, ce} <= 2'b00;
    tick(100);
    @(posedge clk_sys_i) ce <= 1'b1;
    tick(100);
    rreg(8'h04, 32'h7F, 32'h08, "frozen timer");
    tick(90);
    rreg(8'h04, 32'h8007F, 32'h80010, "missed restart");
    duty(4, 16, 8, "miss diagnostic_lamp");
    restart(1'b1);
    tick(25);
    @(posedge clk_sys_i) busy <= 1'b1;
    @(posedge clk_sys_i) {busy, abrt} <= 2'b01;
    tick(3);
    duty(4, 16, 16, "abort diagnostic_lamp");
    give_verdict;
  end
endmodule
